// ---- hw/reference_control_reg.sv ----
// Module: reference control special-function register and its outputs
`timescale 1ns/1ps
module reference_control_reg
    import refctl_pkg::*;
#(
    parameter int BIAS_USERS = 4 // Peripherals that may need the bias
)(
    input wire logic core_clk, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [7:0] sfr_addr, // Special-function address
    input wire logic sfr_wr, // Write strobe, one cycle
    input wire logic sfr_rd, // Read strobe, one cycle
    input wire logic [7:0] sfr_wdata, // Write data
    output logic [7:0] sfr_rdata, // Read data, registered
    output logic sfr_hit, // Address decodes to this register
    input wire logic [BIAS_USERS-1:0] bias_request, // Peripheral enables
    output ref_source_t ref_source, // Converter reference choice
    output logic gain_double, // Buffer at 2x gain
    output logic ref_buffer_on, // Reference buffer drives pin
    output logic bias_on, // Bias generator powered
    output logic temp_sensor_on // Temperature sensor powered
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (BIAS_USERS < 1) begin : g_chk
        $error("BIAS_USERS must be at least one");
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] reference_control; // Stored writable bits
    logic [7:0] next_reference_control;
    logic [7:0] next_sfr_rdata;

    // Page selection is not an input: the register is on every page
    assign sfr_hit = (sfr_addr == REFERENCE_CONTROL_ADDR);

    // Next value of the register and read data
    always_comb begin
        next_reference_control = reference_control;
        next_sfr_rdata = sfr_rdata;
        if (sfr_wr && sfr_hit) begin
            // Unused bits dropped on write
            next_reference_control = sfr_wdata
                & REFERENCE_CONTROL_WMASK;
        end
        if (sfr_rd && sfr_hit) begin
            // Masked again so the unused bits can never leak out
            next_sfr_rdata = reference_control
                & REFERENCE_CONTROL_WMASK;
        end else if (sfr_rd) begin
            // Other addresses belong to other blocks; answer zero
            next_sfr_rdata = 8'h00;
        end
    end

    // Register update
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reference_control <= REFERENCE_CONTROL_RESET;
            sfr_rdata <= 8'h00;
        end else begin
            reference_control <= next_reference_control;
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------------
    ref_source_decode u_decode (
        .ref_source_select(reference_control[REF_SOURCE_SELECT_BIT]),
        .regulator_ref_override(reference_control[REGULATOR_REF_OVERRIDE_BIT]),
        .buffer_gain_select(reference_control[BUFFER_GAIN_SELECT_BIT]),
        .ref_source(ref_source),
        .gain_double(gain_double)
    );

    // Software should clear this when the reference is idle; not forced
    assign ref_buffer_on = reference_control[REF_BUFFER_ENABLE_BIT];
    // Sensor power follows its enable bit with no extra delay
    assign temp_sensor_on =
        reference_control[TEMP_SENSOR_ENABLE_BIT];
    // Any peripheral pulls the bias on without software help
    assign bias_on = reference_control[ANALOG_BIAS_ENABLE_BIT]
        | (|bias_request);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_write(logic [7:0] d);
        sfr_wr && sfr_hit && sfr_wdata == d;
    endsequence

    // Register write with the override bit clear
    sequence s_select_write;
        sfr_wr && sfr_hit && !sfr_wdata[REGULATOR_REF_OVERRIDE_BIT];
    endsequence

    // Register write that sets the software bias request
    sequence s_bias_set;
        sfr_wr && sfr_hit && sfr_wdata[ANALOG_BIAS_ENABLE_BIT];
    endsequence

    // Software request cleared, then no peripheral asks for bias
    sequence s_bias_quiet;
        (sfr_wr && sfr_hit && !sfr_wdata[ANALOG_BIAS_ENABLE_BIT])
            ##1 (bias_request == '0);
    endsequence

    property p_select_pin;
        @(posedge core_clk) disable iff (srst)
        s_write(8'h00) |=> ref_source == REF_FROM_PIN;
    endproperty
    a_select_pin: assert property (p_select_pin)
        else $error("pin reference not selected");

    property p_select_supply;
        @(posedge core_clk) disable iff (srst)
        s_write(8'h08) |=> ref_source == REF_FROM_SUPPLY;
    endproperty
    a_select_supply: assert property (p_select_supply)
        else $error("supply reference not selected");

    // Any write without override: select bit alone picks the source
    property p_select_any;
        @(posedge core_clk) disable iff (srst)
        s_select_write |=> ref_source ==
            ($past(sfr_wdata[REF_SOURCE_SELECT_BIT])
                ? REF_FROM_SUPPLY : REF_FROM_PIN);
    endproperty
    a_select_any: assert property (p_select_any)
        else $error("select bit did not govern the source");

    property p_override;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && sfr_hit && sfr_wdata[4])
            |=> ref_source == REF_FROM_REGULATOR;
    endproperty
    a_override: assert property (p_override)
        else $error("override did not pick regulator");

    property p_gain;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && sfr_hit) |=> gain_double == !$past(sfr_wdata[7]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("buffer gain mismatch");

    property p_buffer;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && sfr_hit) |=> ref_buffer_on == $past(sfr_wdata[0]);
    endproperty
    a_buffer: assert property (p_buffer)
        else $error("buffer enable mismatch");

    property p_bias;
        @(posedge core_clk) disable iff (srst)
        (|bias_request) |-> bias_on;
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias off while requested");

    // Software alone must be able to power the bias
    property p_bias_set;
        @(posedge core_clk) disable iff (srst)
        s_bias_set |=> bias_on;
    endproperty
    a_bias_set: assert property (p_bias_set)
        else $error("bias off after software enable");

    // With no request from anyone the bias must be off
    property p_bias_quiet;
        @(posedge core_clk) disable iff (srst)
        s_bias_quiet |-> !bias_on;
    endproperty
    a_bias_quiet: assert property (p_bias_quiet)
        else $error("bias on with no request");

    property p_temp;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && sfr_hit) |=> temp_sensor_on == $past(sfr_wdata[2]);
    endproperty
    a_temp: assert property (p_temp)
        else $error("sensor enable mismatch");

    property p_unused_zero;
        @(posedge core_clk) disable iff (srst)
        // Compared with the value before the edge: a write in the same
        // cycle as the read must not show up yet
        (sfr_rd && sfr_hit) |=> sfr_rdata[6:5] == 2'b00
            && sfr_rdata[7] == $past(reference_control[7])
            && sfr_rdata[4:0] == $past(reference_control[4:0]);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("readback wrong");

    // Read data stands until the next read strobe
    property p_rdata_hold;
        @(posedge core_clk) disable iff (srst)
        !sfr_rd |=> $stable(sfr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

    // Reads of other addresses answer zero
    property p_other_read;
        @(posedge core_clk) disable iff (srst)
        (sfr_rd && !sfr_hit) |=> sfr_rdata == 8'h00;
    endproperty
    a_other_read: assert property (p_other_read)
        else $error("foreign read returned data");

    property p_addr;
        @(posedge core_clk) disable iff (srst)
        (sfr_wr && !sfr_hit) |=> $stable(reference_control);
    endproperty
    a_addr: assert property (p_addr)
        else $error("write at other address took effect");

    property p_reset;
        @(posedge core_clk)
        srst |=> reference_control == 8'h00 && !ref_buffer_on;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not clear register");

endmodule : reference_control_reg

// ---- pkg/refctl_pkg.sv ----
// Package: register map, field layout and encodings of the reference control
package refctl_pkg;

    // ------------------------------------------------------------------
    // Special-function register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'hd1; // Any page
    localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] REFERENCE_CONTROL_WMASK = 8'h9f; // Bits 6:5 unused

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int REF_BUFFER_ENABLE_BIT = 0;
    localparam int ANALOG_BIAS_ENABLE_BIT = 1;
    localparam int TEMP_SENSOR_ENABLE_BIT = 2;
    localparam int REF_SOURCE_SELECT_BIT = 3;
    localparam int REGULATOR_REF_OVERRIDE_BIT = 4;
    localparam int BUFFER_GAIN_SELECT_BIT = 7;

    // ------------------------------------------------------------------
    // Converter reference source, one-hot towards the analog mux
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        REF_FROM_PIN = 3'h1,
        REF_FROM_SUPPLY = 3'h2,
        REF_FROM_REGULATOR = 3'h4
    } ref_source_t;

endpackage : refctl_pkg

// ---- hw/ref_source_decode.sv ----
// Module: decode of the converter reference source and buffer gain
`timescale 1ns/1ps
module ref_source_decode
    import refctl_pkg::*;
(
    input wire logic ref_source_select, // 0 pin, 1 supply
    input wire logic regulator_ref_override, // 1 forces regulator
    input wire logic buffer_gain_select, // 0 double, 1 unity
    output ref_source_t ref_source, // One-hot source choice
    output logic gain_double // High for 2x buffer gain
);

    // ------------------------------------------------------------------
    // Source priority
    // ------------------------------------------------------------------
    // Override wins so the select bit may be left untouched meanwhile
    always_comb begin
        if (regulator_ref_override) begin
            ref_source = REF_FROM_REGULATOR;
        end else if (ref_source_select) begin
            ref_source = REF_FROM_SUPPLY;
        end else begin
            ref_source = REF_FROM_PIN;
        end
    end

    // Gain bit is inverted: zero means double gain
    assign gain_double = ~buffer_gain_select;

endmodule : ref_source_decode

// ---- testbench/analog_bias_users.sv ----
// Partner model: peripherals that ask the analog bias generator for power
`timescale 1ns/1ps
module analog_bias_users #(
    parameter int BIAS_USERS = 4 // Peripherals that may need the bias
)(
    input wire logic core_clk, // System clock
    input wire logic [BIAS_USERS-1:0] want_bias, // Peripheral enables
    output logic [BIAS_USERS-1:0] bias_request // Requests to the block
);
    // -------------------------------------------------------------
    // Peripheral enables are flops on the system clock
    // -------------------------------------------------------------
    // Registered on the rising edge so a bench change at the falling
    // edge is seen half a cycle later, free of any ordering race
    always @(posedge core_clk) begin
        bias_request <= want_bias;
    end
endmodule : analog_bias_users

// ---- testbench/testbench.sv ----
// Testbench: self-checking bench for the reference control register
`timescale 1ns/1ps
module testbench;
    import refctl_pkg::*;
    logic core_clk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, q;
    logic [3:0] want_bias = 4'h0, bias_request;
    logic sfr_hit, gain_double, ref_buffer_on, bias_on, temp_sensor_on;
    ref_source_t ref_source;
    int n_mismatch = 0, checks_done = 0;
    integer seed = 32'habd83351; // Fixed seed, repeatable run
    logic [7:0] v; // Last value written to the register
    logic [7:0] e, g; // Expected and observed output vectors
    // -------------------------------------------------------------
    // Clock, partner and design
    // -------------------------------------------------------------
    initial forever #2.5 core_clk = ~core_clk;
    analog_bias_users #(.BIAS_USERS(4)) analog_bias_users_inst (
        .core_clk(core_clk), .want_bias(want_bias),
        .bias_request(bias_request));
    reference_control_reg #(.BIAS_USERS(4)) reference_control_reg_inst (
        .core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .bias_request(bias_request), .ref_source(ref_source),
        .gain_double(gain_double), .ref_buffer_on(ref_buffer_on),
        .bias_on(bias_on), .temp_sensor_on(temp_sensor_on));
    // -------------------------------------------------------------
    // Helpers: compare, expected outputs, one bus cycle
    // -------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Override wins over the select bit; bias is an OR of requests
    function automatic logic [7:0] exp_out(logic [7:0] r, logic [3:0] b);
        exp_out = {1'b0, ~r[7], r[0], r[1] | (|b), r[2],
            r[4] ? 3'h4 : (r[3] ? 3'h2 : 3'h1)};
    endfunction : exp_out
    function automatic logic [7:0] got_out();
        got_out = {1'b0, gain_double, ref_buffer_on, bias_on,
            temp_sensor_on, ref_source};
    endfunction : got_out
    // Strobe for one cycle, then an idle cycle so that two calls in a
    // row never drop and raise a strobe in one time step
    task automatic bus(input logic [7:0] a, d, input logic w);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = ~w;
        @(negedge core_clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(negedge core_clk);
        q = sfr_rdata;
    endtask : bus
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        bus(8'hd1, 8'h00, 1'b0);
        chk(q, 8'h00);
        chk(got_out(), exp_out(8'h00, 4'h0));
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            v = 8'($random(seed));
            want_bias = 4'($random(seed));
            // Corner cases first: supply, override, supply again, override over supply
            if (i < 4) v = 8'h08 << (i % 2) | (i > 1 ? 8'h08 : 8'h00);
            bus(8'hd1, v, 1'b1);
            e = exp_out(v, want_bias);
            g = got_out();
            chk(g & 8'h07, e & 8'h07);
            chk(g & 8'h60, e & 8'h60);
            chk(g & 8'h10, e & 8'h10);
            chk(g & 8'h08, e & 8'h08);
            // Any other address must miss, whatever the page
            sfr_addr = 8'hd1 ^ {v[6:0], 1'b1};
            #1 chk({7'h00, sfr_hit}, 8'h00);
            sfr_addr = 8'hd1;
            #1 chk({7'h00, sfr_hit}, 8'h01);
            @(negedge core_clk);
            bus(8'hd1, 8'h00, 1'b0);
            chk(q, v & 8'h9f);
        end
        $display("random test done");
        bus(8'hd0, 8'hff, 1'b1);
        bus(8'hd0, 8'h00, 1'b0);
        chk(q, 8'h00);
        bus(8'hd1, 8'h00, 1'b0);
        chk(q, v & 8'h9f);
        $display("unmapped test done");
        bus(8'hd1, 8'hff, 1'b1);
        srst = 1'b1;
        @(negedge core_clk);
        srst = 1'b0;
        want_bias = 4'h0;
        @(negedge core_clk);
        chk(got_out(), exp_out(8'h00, 4'h0));
        bus(8'hd1, 8'h00, 1'b0);
        chk(q, 8'h00);
        bus(8'hd1, 8'h01, 1'b1);
        chk({7'h00, ref_buffer_on}, 8'h01);
        bus(8'hd1, 8'h00, 1'b1);
        chk({7'h00, ref_buffer_on}, 8'h00);
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule : testbench
